//--- bit_test_skip_decode_test.sv
`timescale 1ns/1ps
// one comparison; case equality so an unknown never matches
`define CHK(act, exp) begin tests_run++; if ((act) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t act %0h exp %0h", $time, (act), (exp)); end end
module bit_test_skip_decode_test
  import btsd_pkg::*;
;
  // =====================================================
  // signals
  logic                 sys_clk;     // core clock
  logic                 reset;       // async, active high
  logic [INSTR_W-1:0]   instrWord;   // word under test
  logic [DATA_W-1:0]    regData;     // register read data
  logic [ADDR_W-1:0]    regAddr;     // read address
  logic                 regRead;     // read strobe
  logic                 execNop;     // discarded cycle
  logic                 isSkipInstr; // skip opcode seen
  logic                 skipTaken;   // skip decided
  logic                 regWrite;    // must stay low
  logic                 wWrite;      // must stay low
  logic                 statusWrite; // must stay low
  logic [PHASE_W-1:0]   phase;       // q phase
  int                   miscompares; // mismatch count
  int                   tests_run;   // comparison count
  btsd_decode DUT (.sys_clk(sys_clk), .reset(reset), .instrWord(instrWord), .regAddr(regAddr),
    .regRead(regRead), .regData(regData), .execNop(execNop), .isSkipInstr(isSkipInstr),
    .skipTaken(skipTaken), .regWrite(regWrite), .wWrite(wWrite), .statusWrite(statusWrite),
    .phase(phase));
  // =====================================================
  // helpers
  // one clock: drive at the edge, judge once it has settled
  task automatic step(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    instrWord <= w;
    regData   <= d;
    #1;
    `CHK({regWrite, wWrite, statusWrite}, 3'h0)
  endtask
  // one instruction cycle, plus the flush cycle when a skip is expected
  task automatic run_test(input logic [3:0] opc, input logic [2:0] b,
                          input logic [7:0] d, input logic isSkip, input logic expSkip);
    int i;
    for (i = 0; i < 12 && phase !== PH_Q4; i++) step(instrWord, regData);
    step({opc, b, b, 4'hA}, d);
    `CHK(phase, PH_Q1)
    `CHK(execNop, 1'b0)
    `CHK(regAddr, {b, 4'hA})
    `CHK(isSkipInstr, isSkip)
    step({opc, b, b, 4'hA}, d);
    `CHK(regRead, isSkip)
    step({opc, b, b, 4'hA}, d);
    step({opc, b, b, 4'hA}, d);
    `CHK(skipTaken, expSkip)
    // a skip word offered in the flush cycle would skip again if it were not refused
    if (expSkip) for (i = 0; i < 4; i++) begin
      step({OPC_SKIP_SET, 10'h3FF}, 8'hFF);
      `CHK(execNop, 1'b1)
      `CHK(regRead | isSkipInstr, 1'b0)
    end
  endtask
  // =====================================================
  // scenarios: bit indices 0 and 7 (7 alone for the clear-test run case, 3 for the set-test run case), other bits opposite
  task automatic t_clear_skip();
    run_test(OPC_SKIP_CLR, 3'h0, 8'hFE, 1'b1, 1'b1);
    run_test(OPC_SKIP_CLR, 3'h7, 8'h7F, 1'b1, 1'b1);
  endtask
  task automatic t_clear_run();
    run_test(OPC_SKIP_CLR, 3'h7, 8'h80, 1'b1, 1'b0);
  endtask
  task automatic t_set_skip();
    run_test(OPC_SKIP_SET, 3'h0, 8'h01, 1'b1, 1'b1);
    run_test(OPC_SKIP_SET, 3'h7, 8'h80, 1'b1, 1'b1);
  endtask
  task automatic t_set_run();
    run_test(OPC_SKIP_SET, 3'h3, 8'hF7, 1'b1, 1'b0);
  endtask
  // neighbouring opcodes must not decode as tests
  task automatic t_other();
    run_test(4'h5, 3'h2, 8'hFF, 1'b0, 1'b0);
    run_test(4'h4, 3'h2, 8'h00, 1'b0, 1'b0);
  endtask
  // =====================================================
  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // watchdog; the whole sequence needs well under 200 clocks
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
  // main sequence, back to back
  initial begin
    miscompares = 0;
    tests_run   = 0;
    reset       = 1'b1;
    instrWord   = 14'h0000;
    regData     = 8'h00;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_clear_skip();
    t_clear_run();
    t_set_skip();
    t_set_run();
    t_other();
    complete_run();
  end
endmodule

//--- btsd_decode.sv
`timescale 1ns/1ps

// =====================================================
// cycle timing, one instruction per four clocks
//   q1  opcode decoded combinationally from instrWord
//   q2  regRead raised toward the register file
//   q3  tested bit taken at the edge that closes q3
//   q4  skipTaken shows the result for this one clock
//   next cycle: execNop stands for all four phases on a skip
// a word offered during the nop slot is ignored outright, so a
// discarded test word can never chain a second skip
// limitation: regData must be steady through q3, because the
// bit is read straight from it with no capture of its own
// trade-off: one flop holds the result from q3 to the end of q4,
// which keeps the nop slot aligned to whole instruction cycles

module btsd_decode
  import btsd_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // instruction from fetch, valid across the cycle
  input  wire logic [INSTR_W-1:0] instrWord,
  // register file read port
  output logic      [ADDR_W-1:0]  regAddr,
  output logic                    regRead,
  input  wire logic [DATA_W-1:0]  regData,
  // core control
  output logic                    execNop,
  output logic                    isSkipInstr,
  output logic                    skipTaken,
  output logic                    regWrite,
  output logic                    wWrite,
  output logic                    statusWrite,
  output logic      [PHASE_W-1:0] phase
);
  // =====================================================
  // phase sequencer
  // a free-running q1..q4 counter; reset always restarts at q1,
  // so the first instruction cycle begins right after release
  btsd_phase_if phIf ();
  btsd_phase_gen u_phase (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ph      (phIf)
  );
  assign phase = phIf.phase;

  // =====================================================
  // decode
  // both opcodes share bits 13:11, differing only in bit 10;
  // the bit index and address fields sit at the same place
  // for either, so one selector serves both tests
  logic              isClr;     // clear-test opcode
  logic              isSet;     // set-test opcode
  logic [BIDX_W-1:0] bitIdx;    // bit selector
  logic              testBit;   // selected bit value
  logic              skipNow;   // skip condition

  always_comb begin
    isClr   = instrWord[OPC_HI:OPC_LO] == OPC_SKIP_CLR;
    isSet   = instrWord[OPC_HI:OPC_LO] == OPC_SKIP_SET;
    bitIdx  = instrWord[BIT_HI:BIT_LO];
    testBit = regData[bitIdx];
    // clear-test skips on 0, set-test skips on 1
    skipNow = (isClr && !testBit) || (isSet && testBit);
  end

  // =====================================================
  // skip state and captured result
  btsd_state_t state_q;  // run or flushing slot
  btsd_state_t state_d;
  logic        skip_q;   // result latched in q3
  logic        skip_d;

  // state only moves at cycle end, so a skip always spans whole cycles
  // the result flop is cleared at every cycle end, so a stale
  // result can never be applied again to a later instruction
  always_comb begin
    state_d = state_q;
    skip_d  = skip_q;
    case (state_q)
      BTSD_RUN: begin
        if (phIf.phase == PH_Q3) begin
          skip_d = skipNow;
        end
        if (phIf.cycEnd) begin
          // bit one (clear) or zero (set) stays in run
          state_d = skip_q ? BTSD_FLUSH : BTSD_RUN;
          skip_d  = 1'b0;
        end
      end
      BTSD_FLUSH: begin
        // exactly one nop cycle, then back
        if (phIf.cycEnd) begin
          state_d = BTSD_RUN;
        end
      end
      default: begin
        state_d = BTSD_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= BTSD_RUN;
      skip_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      skip_q  <= skip_d;
    end
  end

  // =====================================================
  // outputs
  // handshake-style strobes are combinational from state and
  // phase; the write enables are tied low since neither test
  // touches the register file, w or status
  always_comb begin
    regAddr     = instrWord[ADDR_HI:ADDR_LO];
    // read only in q2 of a real test cycle
    regRead     = (state_q == BTSD_RUN) && (isClr || isSet) && (phIf.phase == PH_Q2);
    isSkipInstr = (state_q == BTSD_RUN) && (isClr || isSet);
    skipTaken   = skip_q;
    // whole discarded cycle is nop, all four phases
    execNop     = (state_q == BTSD_FLUSH);
    // tests never write anything
    regWrite    = 1'b0;
    wWrite      = 1'b0;
    statusWrite = 1'b0;
  end

  // =====================================================
  // checks
  // all assertions run on sys_clk and are muted while reset is high;
  // the q3 sample feeds the nop slot two edges later, one edge
  // for the q4 phase and one for the move into the flush state
  chk_flush_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(execNop) |-> execNop [*4] ##1 !execNop)
    else $error("nop slot not four phases");
  chk_clr_skip: assert property (@(posedge sys_clk) disable iff (reset)
    (phIf.phase == PH_Q3 && state_q == BTSD_RUN && isClr && !testBit)
      |-> ##2 execNop)
    else $error("clear-test did not skip");
  chk_clr_noskip: assert property (@(posedge sys_clk) disable iff (reset)
    (phIf.phase == PH_Q3 && state_q == BTSD_RUN && isClr && testBit)
      |-> ##2 !execNop)
    else $error("clear-test skipped on one");
  chk_set_skip: assert property (@(posedge sys_clk) disable iff (reset)
    (phIf.phase == PH_Q3 && state_q == BTSD_RUN && isSet && testBit)
      |-> ##2 execNop)
    else $error("set-test did not skip");
  chk_set_noskip: assert property (@(posedge sys_clk) disable iff (reset)
    (phIf.phase == PH_Q3 && state_q == BTSD_RUN && isSet && !testBit)
      |-> ##2 !execNop)
    else $error("set-test skipped on zero");
  chk_no_writes: assert property (@(posedge sys_clk) disable iff (reset)
    !(regWrite || wWrite || statusWrite))
    else $error("skip test wrote state");
  chk_clr_decode: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == BTSD_RUN && instrWord[OPC_HI:OPC_LO] == OPC_SKIP_CLR
      && phIf.phase == PH_Q2) |-> regRead)
    else $error("clear-test not decoded");
  chk_set_decode: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == BTSD_RUN && instrWord[OPC_HI:OPC_LO] == OPC_SKIP_SET
      && phIf.phase == PH_Q2) |-> regRead)
    else $error("set-test not decoded");

  // result shows for exactly one clock
  chk_taken_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    skipTaken |=> !skipTaken)
    else $error("skip result held too long");

  // result only shows in the last phase
  chk_taken_in_q4: assert property (@(posedge sys_clk) disable iff (reset)
    skipTaken |-> phIf.phase == PH_Q4)
    else $error("skip result outside q4");

  // a taken skip is always followed by the nop slot
  chk_nop_follows: assert property (@(posedge sys_clk) disable iff (reset)
    skipTaken |=> execNop)
    else $error("no nop slot after skip");

  // the discarded word is never read or decoded
  chk_flush_refused: assert property (@(posedge sys_clk) disable iff (reset)
    execNop |-> !regRead && !isSkipInstr)
    else $error("word decoded in nop slot");

  // register read strobe only in q2
  chk_read_in_q2: assert property (@(posedge sys_clk) disable iff (reset)
    regRead |-> phIf.phase == PH_Q2)
    else $error("register read outside q2");

  // nop slot starts on a cycle boundary
  chk_nop_starts_q1: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(execNop) |-> phIf.phase == PH_Q1)
    else $error("nop slot not aligned");

  // no skip result, no nop slot
  chk_run_no_nop: assert property (@(posedge sys_clk) disable iff (reset)
    (phIf.phase == PH_Q4 && state_q == BTSD_RUN && !skipTaken) |=> !execNop)
    else $error("nop slot without skip");

  // main scenarios seen
  cov_clr_skip: cover property (@(posedge sys_clk) isClr && skipNow && phIf.phase == PH_Q3);
  cov_clr_run:  cover property (@(posedge sys_clk) isClr && !skipNow && phIf.phase == PH_Q3);
  cov_set_run:  cover property (@(posedge sys_clk) isSet && !skipNow && phIf.phase == PH_Q3);
  cov_set_skip: cover property (@(posedge sys_clk) isSet && skipNow && phIf.phase == PH_Q3);
  cov_flush:    cover property (@(posedge sys_clk) $fell(execNop));
endmodule

//--- btsd_phase_gen.sv
`timescale 1ns/1ps
// =====================================================
// four-phase sequencer
module btsd_phase_gen
  import btsd_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // phase outputs
  btsd_phase_if.gen ph
);
  logic [PHASE_W-1:0] phase_q; // phase counter
  logic [PHASE_W-1:0] phase_d; // next phase

  // wrap q4 back to q1
  always_comb begin
    phase_d = (phase_q == PH_Q4) ? PH_Q1 : phase_q + 2'h1;
  end

  // register phase
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign ph.phase  = phase_q;
  assign ph.cycEnd = (phase_q == PH_Q4);
endmodule

//--- btsd_phase_if.sv
`timescale 1ns/1ps
// phase sequencer to decoder carrier
interface btsd_phase_if;
  logic [1:0] phase;  // current q phase
  logic       cycEnd; // last phase of instruction cycle
  modport gen (output phase, output cycEnd);
  modport use_ (input phase, input cycEnd);
endinterface

//--- btsd_pkg.sv
package btsd_pkg;
  // =====================================================
  // instruction word layout
  localparam int INSTR_W    = 14;
  localparam int OPC_HI     = 13;
  localparam int OPC_LO     = 10;
  localparam int BIT_HI     = 9;
  localparam int BIT_LO     = 7;
  localparam int ADDR_HI    = 6;
  localparam int ADDR_LO    = 0;
  localparam int ADDR_W     = 7;
  localparam int BIDX_W     = 3;
  localparam int DATA_W     = 8;
  // opcode patterns in the top four bits
  localparam logic [3:0] OPC_SKIP_CLR = 4'h6;
  localparam logic [3:0] OPC_SKIP_SET = 4'h7;
  // four-phase instruction cycle
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PH_Q1 = 2'h0;
  localparam logic [PHASE_W-1:0] PH_Q2 = 2'h1;
  localparam logic [PHASE_W-1:0] PH_Q3 = 2'h2;
  localparam logic [PHASE_W-1:0] PH_Q4 = 2'h3;
  // skip-cycle states
  typedef enum logic [0:0] {BTSD_RUN, BTSD_FLUSH} btsd_state_t;
endpackage
